// ### rtl/scr_aux_cycle.sv
/*
 * Auxiliary regulator sequencer: continuous, off or cyclic on-windows.
 * Assumes a one-cycle microsecond tick from the parent's divider.
 */
`timescale 1ns/10ps
module scr_aux_cycle #(
    parameter int ON_US      = 350,
    parameter int PERIOD1_US = 16000,
    parameter int PERIOD2_US = 32000
) (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_tick,
    input  wire scr_pkg::scr_aux_mode_t i_mode,
    output logic                        o_aux_on,
    output logic                        o_window_end
);

    scr_pkg::scr_seq_state_t state;
    logic [15:0]             count;
    logic [15:0]             period_us;

    always_comb begin
        if (i_mode == scr_pkg::SCR_AUX_CYCLIC2) begin
            period_us = 16'(PERIOD2_US);
        end else begin
            period_us = 16'(PERIOD1_US);
        end
    end

    // Leaving off or on restarts the period; a switch between the two cyclic codes keeps the count
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state        <= scr_pkg::SCR_SEQ_IDLE;
            count        <= 16'h0000;
            o_aux_on     <= 1'b0;
            o_window_end <= 1'b0;
        end else begin
            o_window_end <= 1'b0;
            case (i_mode)
                scr_pkg::SCR_AUX_OFF: begin
                    state    <= scr_pkg::SCR_SEQ_IDLE;
                    o_aux_on <= 1'b0;
                end
                scr_pkg::SCR_AUX_ON: begin
                    state    <= scr_pkg::SCR_SEQ_IDLE;
                    o_aux_on <= 1'b1;
                end
                default: begin
                    case (state)
                        scr_pkg::SCR_SEQ_IDLE: begin
                            state    <= scr_pkg::SCR_SEQ_ON;
                            count    <= 16'h0000;
                            o_aux_on <= 1'b1;
                        end
                        scr_pkg::SCR_SEQ_ON: begin
                            if (i_tick) begin
                                count <= count + 16'h0001;
                                if (count == 16'(ON_US - 1)) begin
                                    state        <= scr_pkg::SCR_SEQ_WAIT;
                                    o_aux_on     <= 1'b0;
                                    o_window_end <= 1'b1;
                                end
                            end
                        end
                        scr_pkg::SCR_SEQ_WAIT: begin
                            if (i_tick) begin
                                count <= count + 16'h0001;
                                if (count >= period_us - 16'h0001) begin
                                    state    <= scr_pkg::SCR_SEQ_ON;
                                    count    <= 16'h0000;
                                    o_aux_on <= 1'b1;
                                end
                            end
                        end
                        default: begin
                            state <= scr_pkg::SCR_SEQ_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

endmodule

// ### rtl/scr_pkg.sv
/*
 * Constants, field layout and state types shared by the system
 * configuration register block and its auxiliary regulator sequencer.
 * Assumes one 125 MHz logic clock and a 16-bit word-wide register port.
 */
package scr_pkg;

    // Register port offsets
    localparam logic [7:0] ADDR_ACCESS      = 8'h00;
    localparam logic [7:0] ADDR_CONFIG_FB   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h10;

    // Access word fields
    localparam int         POS_REG_SEL      = 14;
    localparam logic [1:0] REG_SEL_CONFIG   = 2'h2;
    localparam int         POS_READBACK_SEL = 13;
    localparam int         POS_NO_WRITE     = 12;

    localparam logic [15:0] CONFIG_RESET    = 16'h0100;
    // Bits that the register really stores (reserved ones read zero)
    localparam logic [15:0] CONFIG_STORED   = 16'h03fd;

    // Interrupt status bit positions
    localparam int IRQ_GROUND_SHIFT = 0;
    localparam int IRQ_WAKE         = 1;
    localparam int IRQ_CURRENT_RST  = 2;
    localparam int IRQ_AUX_FORCED   = 3;
    localparam int IRQ_WIDTH        = 4;

    // Timing: microsecond tick from the logic clock
    localparam int CLK_PERIOD_NS    = 8;
    localparam int TICK_NS          = 1000;
    localparam int TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
    localparam int AUX_ON_US        = 350;
    localparam int AUX_PERIOD1_MS   = 16;
    localparam int AUX_PERIOD2_MS   = 32;
    localparam int RESET_LONG_MS    = 20;
    localparam int RESET_SHORT_MS   = 1;
    localparam int US_PER_MS        = 1000;
    localparam int AUX_PERIOD1_US   = AUX_PERIOD1_MS * US_PER_MS;
    localparam int AUX_PERIOD2_US   = AUX_PERIOD2_MS * US_PER_MS;
    localparam int RESET_LONG_US    = RESET_LONG_MS * US_PER_MS;
    localparam int RESET_SHORT_US   = RESET_SHORT_MS * US_PER_MS;

    typedef enum logic [1:0] {
        SCR_AUX_OFF     = 2'h0,
        SCR_AUX_ON      = 2'h1,
        SCR_AUX_CYCLIC1 = 2'h2,
        SCR_AUX_CYCLIC2 = 2'h3
    } scr_aux_mode_t;

    typedef struct packed {
        logic [1:0]    register_select_bits;
        logic          readback_select;
        logic          no_write_flag;
        logic [1:0]    reserved_hi;
        logic          ground_shift_level_sel;
        logic          reset_pulse_length_sel;
        scr_aux_mode_t aux_regulator_mode;
        logic          main_reg_undervolt_sel;
        logic          main_reg_current_watch;
        logic          wake_enable;
        logic          wake_pin_sampling;
        logic          reserved_lo;
        logic          inhibit_control_bit;
    } scr_cfg_t;

    typedef enum logic [1:0] {
        SCR_RST_IDLE  = 2'h0,
        SCR_RST_PULSE = 2'h1
    } scr_rst_state_t;

    typedef enum logic [1:0] {
        SCR_SEQ_IDLE = 2'h0,
        SCR_SEQ_ON   = 2'h1,
        SCR_SEQ_WAIT = 2'h2
    } scr_seq_state_t;

endpackage

// ### rtl/scr_system_config.sv
/*
 * System configuration register with its control outputs: readback
 * selection, read-only accesses, fault forcing of the auxiliary mode,
 * reset pulse timing, wake sampling and a masked interrupt.
 * Assumes all pin-level inputs are synchronous to i_ref_clk and that
 * the host drives one strobe at a time on the register port.
 */
`timescale 1ns/10ps
// How it works
// - Select 0 returns configuration feedback
// - Select 1 returns general feedback
// - Top bits 10 target this register
// - Read-only clear: return and update
// - Ground-shift level selects interrupt threshold
// - Reset length 20 ms default, 1 ms
// - Aux mode: off, on, two cyclic
// - Faults force aux mode to off
// - Undervolt bit selects reduced threshold
// - Current watch: reset or watchdog restart
// - Wake sampling cyclic or continuous
// - Inhibit bit drives inhibit output high
module scr_system_config #(
    parameter int AUX_ON_US      = scr_pkg::AUX_ON_US,
    parameter int AUX_PERIOD1_US = scr_pkg::AUX_PERIOD1_US,
    parameter int AUX_PERIOD2_US = scr_pkg::AUX_PERIOD2_US,
    parameter int RESET_LONG_US  = scr_pkg::RESET_LONG_US,
    parameter int RESET_SHORT_US = scr_pkg::RESET_SHORT_US
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic [15:0] i_general_feedback_reg,
    input  wire logic        i_fail_safe,
    input  wire logic        i_external_reset_pin,
    input  wire logic        i_aux_short,
    input  wire logic        i_gnd_shift_over_low,
    input  wire logic        i_gnd_shift_over_high,
    input  wire logic        i_main_current_rise,
    input  wire logic        i_watchdog_off_standby,
    input  wire logic        i_reset_request,
    input  wire logic        i_wake_pin,
    output logic             o_inhibit_limp_output,
    output logic             o_ground_shift_level_sel,
    output logic             o_main_reg_undervolt_sel,
    output logic             o_aux_regulator_on,
    output logic             o_system_reset,
    output logic             o_watchdog_restart,
    output logic             o_wake_event,
    output logic             o_irq
);

    scr_pkg::scr_cfg_t          cfg;
    scr_pkg::scr_cfg_t          wr_word;
    scr_pkg::scr_rst_state_t    rst_state;
    logic [15:0]                config_fb;
    logic [15:0]                access_resp;
    logic [scr_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [scr_pkg::IRQ_WIDTH-1:0] irq_enable;
    logic [scr_pkg::IRQ_WIDTH-1:0] irq_event;
    logic [scr_pkg::IRQ_WIDTH-1:0] irq_clear;
    logic [6:0]                 tick_div;
    logic                       tick;
    logic                       ext_reset_prev;
    logic                       aux_force;
    logic                       access_hit;
    logic                       cfg_write;
    logic                       gnd_over_sel;
    logic                       gnd_over_prev;
    logic                       current_reset;
    logic                       reset_start;
    logic [15:0]                reset_count;
    logic [15:0]                reset_len_us;
    logic                       aux_on;
    logic                       aux_window_end;
    logic                       wake_sample_en;
    logic                       wake_sampled;
    logic                       wake_seen;
    logic                       wake_change;

    assign wr_word = scr_pkg::scr_cfg_t'(i_wdata);

    // Readback image: stored fields, selector bits show this register
    always_comb begin
        config_fb = 16'(cfg) & scr_pkg::CONFIG_STORED;
        config_fb[scr_pkg::POS_REG_SEL +: 2] = scr_pkg::REG_SEL_CONFIG;
    end

    assign access_hit = i_wr && (i_addr == scr_pkg::ADDR_ACCESS)
        && (wr_word.register_select_bits == scr_pkg::REG_SEL_CONFIG);
    assign cfg_write = access_hit && !wr_word.no_write_flag;

    assign aux_force = i_fail_safe || i_aux_short
        || (ext_reset_prev && !i_external_reset_pin);

    // Microsecond tick divider
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_div <= 7'h00;
            tick     <= 1'b0;
        end else if (tick_div == 7'(scr_pkg::TICK_CYCLES - 1)) begin
            tick_div <= 7'h00;
            tick     <= 1'b1;
        end else begin
            tick_div <= tick_div + 7'h01;
            tick     <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_reset_prev <= 1'b1;
        end else begin
            ext_reset_prev <= i_external_reset_pin;
        end
    end

    // Configuration storage; reserved and selector bits are not kept
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg <= scr_pkg::scr_cfg_t'(scr_pkg::CONFIG_RESET);
        end else begin
            if (cfg_write) begin
                cfg <= scr_pkg::scr_cfg_t'(i_wdata & scr_pkg::CONFIG_STORED);
            end
            if (aux_force) begin
                cfg.aux_regulator_mode <= scr_pkg::SCR_AUX_OFF;
            end
        end
    end

    // Response is taken from the contents before this access
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            access_resp <= 16'h0000;
        end else if (access_hit) begin
            if (wr_word.readback_select) begin
                access_resp <= i_general_feedback_reg;
            end else begin
                access_resp <= config_fb;
            end
        end
    end

    // Read port
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                scr_pkg::ADDR_ACCESS:     o_rdata <= access_resp;
                scr_pkg::ADDR_CONFIG_FB:  o_rdata <= config_fb;
                scr_pkg::ADDR_IRQ_STATUS: o_rdata <= 16'(irq_status);
                scr_pkg::ADDR_IRQ_ENABLE: o_rdata <= 16'(irq_enable);
                default:                  o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    assign gnd_over_sel = cfg.ground_shift_level_sel
        ? i_gnd_shift_over_high : i_gnd_shift_over_low;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            gnd_over_prev <= 1'b0;
        end else begin
            gnd_over_prev <= gnd_over_sel;
        end
    end

    // reset only if watch set and watchdog off
    assign current_reset = i_main_current_rise && cfg.main_reg_current_watch
        && i_watchdog_off_standby;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_watchdog_restart <= 1'b0;
        end else begin
            o_watchdog_restart <= i_main_current_rise && !current_reset;
        end
    end

    assign reset_len_us = cfg.reset_pulse_length_sel
        ? 16'(RESET_LONG_US) : 16'(RESET_SHORT_US);
    assign reset_start  = i_reset_request || current_reset;

    // A new request during a pulse restarts the full length
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_state      <= scr_pkg::SCR_RST_IDLE;
            reset_count    <= 16'h0000;
            o_system_reset <= 1'b0;
        end else begin
            case (rst_state)
                scr_pkg::SCR_RST_IDLE: begin
                    if (reset_start) begin
                        rst_state      <= scr_pkg::SCR_RST_PULSE;
                        reset_count    <= 16'h0000;
                        o_system_reset <= 1'b1;
                    end
                end
                scr_pkg::SCR_RST_PULSE: begin
                    if (reset_start) begin
                        reset_count <= 16'h0000;
                    end else if (tick) begin
                        reset_count <= reset_count + 16'h0001;
                        // Count one extra tick so the pulse never runs short
                        if (reset_count >= reset_len_us) begin
                            rst_state      <= scr_pkg::SCR_RST_IDLE;
                            o_system_reset <= 1'b0;
                        end
                    end
                end
                default: begin
                    rst_state      <= scr_pkg::SCR_RST_IDLE;
                    o_system_reset <= 1'b0;
                end
            endcase
        end
    end

    scr_aux_cycle #(
        .ON_US      (AUX_ON_US),
        .PERIOD1_US (AUX_PERIOD1_US),
        .PERIOD2_US (AUX_PERIOD2_US)
    ) u_aux_cycle (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_tick       (tick),
        .i_mode       (cfg.aux_regulator_mode),
        .o_aux_on     (aux_on),
        .o_window_end (aux_window_end)
    );

    // cyclic sampling rides the aux on-window
    assign wake_sample_en = cfg.wake_pin_sampling
        ? aux_window_end : 1'b1;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_sampled <= 1'b1;
            wake_seen    <= 1'b0;
        end else if (wake_sample_en) begin
            wake_sampled <= i_wake_pin;
            wake_seen    <= 1'b1;
        end
    end

    assign wake_change = cfg.wake_enable && wake_sample_en && wake_seen
        && (i_wake_pin != wake_sampled);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wake_event <= 1'b0;
        end else begin
            o_wake_event <= wake_change;
        end
    end

    // Interrupt events
    always_comb begin
        irq_event = '0;
        irq_event[scr_pkg::IRQ_GROUND_SHIFT] = gnd_over_sel && !gnd_over_prev;
        irq_event[scr_pkg::IRQ_WAKE]         = wake_change;
        irq_event[scr_pkg::IRQ_CURRENT_RST]  = current_reset;
        irq_event[scr_pkg::IRQ_AUX_FORCED]   = aux_force
            && (cfg.aux_regulator_mode != scr_pkg::SCR_AUX_OFF);
    end

    assign irq_clear = (i_wr && i_addr == scr_pkg::ADDR_IRQ_CLEAR)
        ? i_wdata[scr_pkg::IRQ_WIDTH-1:0] : '0;

    // Set beats clear so no event is lost
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_enable <= '0;
        end else if (i_wr && i_addr == scr_pkg::ADDR_IRQ_ENABLE) begin
            irq_enable <= i_wdata[scr_pkg::IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((irq_status & ~irq_clear) | irq_event) & irq_enable);
        end
    end

    // Registered copies of the steering bits and of the aux sequencer output
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_inhibit_limp_output    <= 1'b0;
            o_ground_shift_level_sel <= 1'b0;
            o_main_reg_undervolt_sel <= 1'b0;
            o_aux_regulator_on       <= 1'b0;
        end else begin
            o_inhibit_limp_output    <= cfg.inhibit_control_bit;
            o_ground_shift_level_sel <= cfg.ground_shift_level_sel;
            o_main_reg_undervolt_sel <= cfg.main_reg_undervolt_sel;
            o_aux_regulator_on       <= aux_on;
        end
    end

endmodule

// ### tb/scr_host_model.sv
/* Host model: register port master of the configuration block.
   Assumes its tasks are called one at a time. */
`timescale 1ns/10ps
module scr_host_model (
    input  wire logic        i_ref_clk,
    input  wire logic [15:0] i_rdata,
    output logic      [7:0]  o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial {o_addr, o_wdata, o_wr, o_rd} = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        o_addr  <= a;
        o_wdata <= (a == 8'h00) ? (d & 16'hf3ff) : d;
        o_wr    <= 1'b1;
        @(posedge i_ref_clk);
        o_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_ref_clk);
        o_rd   <= 1'b0;
        @(posedge i_ref_clk);
        d = i_rdata;
    endtask
endmodule

// ### tb/scr_system_config_checker.sv
/* Port checker of the configuration register, bound to the block.
   Assumes one clock domain and the access word layout. */
`timescale 1ns/10ps
module scr_system_config_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        i_fail_safe,
    input wire logic        i_main_current_rise,
    input wire logic        i_watchdog_off_standby,
    input wire logic        i_reset_request,
    input wire logic        o_inhibit_limp_output,
    input wire logic        o_ground_shift_level_sel,
    input wire logic        o_main_reg_undervolt_sel,
    input wire logic        o_aux_regulator_on,
    input wire logic        o_system_reset,
    input wire logic        o_watchdog_restart,
    input wire logic        o_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic       acc;
    logic       upd;
    logic [2:0] outs;
    assign acc  = i_wr && i_addr == 8'h00;
    assign upd  = acc && i_wdata[15:14] == 2'h2 && !i_wdata[12];
    assign outs = {o_ground_shift_level_sel, o_main_reg_undervolt_sel,
                   o_inhibit_limp_output};
    AST_INHIBIT: assert property (
        upd |-> ##2 o_inhibit_limp_output == $past(i_wdata[0], 2))
        else $error("inhibit output wrong");
    AST_GND_LEVEL: assert property (
        upd |-> ##2 o_ground_shift_level_sel == $past(i_wdata[9], 2))
        else $error("ground level output wrong");
    AST_NO_WRITE: assert property (
        acc && i_wdata[15:14] == 2'h2 && i_wdata[12] |=> ##1 $stable(outs))
        else $error("read-only access changed config");
    AST_WRONG_SEL: assert property (
        acc && i_wdata[15:14] != 2'h2 |=> ##1 $stable(outs))
        else $error("foreign access changed config");
    AST_FB_READ: assert property (
        i_rd && i_addr == 8'h04 |=> o_rdata[15:14] == 2'h2 &&
        {o_rdata[9], o_rdata[5], o_rdata[0]} == outs)
        else $error("feedback read wrong");
    AST_RST_PULSE: assert property (
        i_reset_request |=> o_system_reset)
        else $error("reset pulse missing");
    AST_FAULT_OFF: assert property (
        i_fail_safe |-> ##[1:4] !o_aux_regulator_on)
        else $error("aux not off on fault");
    AST_WD_RESTART: assert property (
        i_main_current_rise && !i_watchdog_off_standby |=> o_watchdog_restart)
        else $error("watchdog restart missing");
    COV_WRITE: cover property (upd);
    COV_RESET: cover property ($rose(o_system_reset));
    COV_IRQ: cover property ($rose(o_irq));
endmodule

bind scr_system_config scr_system_config_checker u_scr_system_config_checker (
    .i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_fail_safe, .i_main_current_rise, .i_watchdog_off_standby,
    .i_reset_request, .o_inhibit_limp_output, .o_ground_shift_level_sel,
    .o_main_reg_undervolt_sel, .o_aux_regulator_on, .o_system_reset,
    .o_watchdog_restart, .o_irq);

// ### tb/scr_system_config_tb.sv
/* Bench of the configuration register: host model on the register
   port, pins driven here. Assumes shortened timing parameters. */
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module scr_system_config_tb;
    logic        clk, rst, fs, xr, sh, glo, ghi, cur, rrq, wdo, wk, wr, rq;
    logic        inh, gsel, uv, aux, srst, wdr, wev, irq, seen;
    logic [7:0]  addr;
    logic [15:0] gpf, wdata, rdata, rd;
    int          fail_count = 0, n_checks = 0, lo, hi, p;
    scr_host_model u_scr_host_model (.i_ref_clk(clk), .i_rdata(rdata),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rq));
    scr_system_config #(.AUX_ON_US(3), .AUX_PERIOD1_US(10),
        .AUX_PERIOD2_US(20), .RESET_LONG_US(8), .RESET_SHORT_US(2))
    u_scr_system_config (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rq), .o_rdata(rdata),
        .i_general_feedback_reg(gpf), .i_fail_safe(fs),
        .i_external_reset_pin(xr), .i_aux_short(sh),
        .i_gnd_shift_over_low(glo), .i_gnd_shift_over_high(ghi),
        .i_main_current_rise(cur), .i_watchdog_off_standby(wdo),
        .i_reset_request(rrq), .i_wake_pin(wk),
        .o_inhibit_limp_output(inh), .o_ground_shift_level_sel(gsel),
        .o_main_reg_undervolt_sel(uv), .o_aux_regulator_on(aux),
        .o_system_reset(srst), .o_watchdog_restart(wdr),
        .o_wake_event(wev), .o_irq(irq));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task test_done;
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task w(input logic [7:0] a, input logic [15:0] d);
        u_scr_host_model.wr(a, d);
    endtask
    task r(input logic [7:0] a);
        u_scr_host_model.rd(a, rd);
    endtask
    // One-cycle pulse on {glo, ghi, cur, rrq}
    task pin(input logic [3:0] v);
        @(posedge clk);
        {glo, ghi, cur, rrq} <= v;
        @(posedge clk);
        {glo, ghi, cur, rrq} <= 4'h0;
    endtask
    // Low then high time of reset (k=1) or aux output
    task meas(input bit k);
        lo = 0;
        hi = 0;
        while ((k ? srst : aux) !== 1'b1 && lo < 6000) begin
            @(posedge clk);
            lo++;
        end
        while ((k ? srst : aux) === 1'b1 && hi < 6000) begin
            @(posedge clk);
            hi++;
        end
        if (lo == 6000 || hi == 6000) begin
            fail_count++;
            test_done();
        end
    endtask
    task wait_wev(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            seen |= wev;
        end
    endtask
    task t_regs;
        r(8'h04);
        `CHK(rd, 16'h8100)
        r(8'h10);
        `CHK(rd, 16'h0000)
        r(8'h40);
        `CHK(rd, 16'h0000)
        w(8'h00, 16'h8009);
        cyc(2);
        `CHK(inh, 1'b1)
        r(8'h00);
        `CHK(rd, 16'h8100)
        w(8'h00, 16'hb000);
        r(8'h00);
        `CHK(rd, 16'h5a5a)
        w(8'h00, 16'h4222);
        r(8'h04);
        `CHK(rd, 16'h8009)
        w(8'h00, 16'h8223);
        cyc(2);
        `CHK({gsel, uv, inh}, 3'h7)
        r(8'h04);
        `CHK(rd, 16'h8221)
    endtask
    task t_aux;
        for (int f = 0; f < 3; f++) begin
            w(8'h00, 16'h8040);
            cyc(4);
            `CHK(aux, 1'b1)
            {fs, xr, sh} <= (f == 0) ? 3'h6 : (f == 1) ? 3'h0 : 3'h3;
            @(posedge clk);
            {fs, xr, sh} <= 3'h2;
            cyc(4);
            `CHK(aux, 1'b0)
            r(8'h04);
            `CHK(rd[7:6], 2'h0)
        end
        for (int m = 2; m < 4; m++) begin
            p = (m - 1) * 1250;
            w(8'h00, 16'h8000 | 16'(m << 6));
            meas(1'b0);
            meas(1'b0);
            `CHK(hi inside {[370:505]}, 1'b1)
            `CHK((lo + hi) inside {[p - 130:p + 130]}, 1'b1)
        end
        w(8'h00, 16'h8000);
        cyc(4);
        `CHK(aux, 1'b0)
    endtask
    task t_rst;
        for (int k = 0; k < 2; k++) begin
            p = (k == 0) ? 1000 : 250;
            w(8'h00, (k == 0) ? 16'h8100 : 16'h8000);
            pin(4'h1);
            meas(1'b1);
            `CHK(hi inside {[p - 5:p + 130]}, 1'b1)
        end
        w(8'h00, 16'h8010);
        wdo <= 1'b1;
        pin(4'h2);
        #1 `CHK({wdr, srst}, 2'h1)
        meas(1'b1);
        r(8'h08);
        `CHK(rd[2], 1'b1)
        w(8'h00, 16'h8000);
        pin(4'h2);
        #1 `CHK({wdr, srst}, 2'h2)
        @(posedge clk);
        wdo <= 1'b0;
        pin(4'h2);
    endtask
    task t_irq;
        for (int g = 0; g < 2; g++) begin
            w(8'h10, 16'h0001);
            w(8'h00, (g == 0) ? 16'h8000 : 16'h8200);
            pin((g == 0) ? 4'h4 : 4'h8);
            cyc(2);
            `CHK(irq, 1'b0)
            pin((g == 0) ? 4'h8 : 4'h4);
            cyc(2);
            `CHK(irq, 1'b1)
            w(8'h10, 16'h0000);
            cyc(2);
            `CHK(irq, 1'b0)
            r(8'h08);
            `CHK(rd[0], 1'b1)
            w(8'h0c, 16'h000f);
            r(8'h08);
            `CHK(rd, 16'h0000)
        end
    endtask
    task t_wake;
        w(8'h00, 16'h8008);
        wk <= 1'b1;
        wait_wev(10);
        `CHK(seen, 1'b1)
        w(8'h00, 16'h8000);
        wk <= 1'b0;
        wait_wev(10);
        `CHK(seen, 1'b0)
        w(8'h00, 16'h808c);
        wk <= 1'b1;
        wait_wev(3000);
        `CHK(seen, 1'b1)
    endtask
    initial begin
        {rst, fs, sh, glo, ghi, cur, rrq, wdo, wk} = 9'h100;
        xr = 1'b1;
        gpf = 16'h5a5a;
        cyc(20);
        rst <= 1'b0;
        t_regs();
        t_aux();
        t_rst();
        t_irq();
        t_wake();
        test_done();
    end
endmodule
